// >>> rtl/himc_pkg.sv
package himc_pkg;
  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [7:0] CMD_SET_RD = 8'h04;
  localparam logic [7:0] CMD_CLR_RD = 8'h05;
  localparam logic [7:0] CMD_SET_WR = 8'h84;
  localparam logic [7:0] CMD_CLR_WR = 8'h85;
  localparam logic [7:0] CMD_EVT_RD = 8'h03;
  localparam logic [7:0] CMD_EVT_WR = 8'h83;
  // ****************************************************************
  // bit positions
  // ****************************************************************
  localparam int BIT_GATE = 31;
  localparam int BIT_ROOT = 6;
  localparam int BIT_FWRAP = 5;
  localparam int BIT_FATAL = 4;
  localparam int BIT_RESUME = 3;
  localparam int BIT_FSTART = 2;
  localparam int BIT_OVERRUN = 0;
  localparam logic [31:0] MASK_VALID = 32'h8000_007D;
  localparam logic [31:0] EVT_VALID = 32'h0000_007D;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] EVT_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage

// >>> rtl/himc_reg_update.sv
`timescale 1ns/1ps
module himc_reg_update (
  // current value and write data
  input wire logic [31:0] cur_i,
  input wire logic [31:0] wdata_i,
  // write kind
  input wire logic set_i,
  input wire logic clr_i,
  // result
  output logic [31:0] nxt_o
);
  // only ones act; reserved positions are filtered by the valid mask
  always_comb begin
    nxt_o = cur_i;
    if (set_i) begin
      nxt_o = cur_i | (wdata_i & himc_pkg::MASK_VALID);
    end else if (clr_i) begin
      nxt_o = cur_i & ~(wdata_i & himc_pkg::MASK_VALID);
    end
  end
endmodule

// >>> rtl/himc_top.sv
`timescale 1ns/1ps
module himc_top (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // host command port
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [31:0] cmd_wdata_i,
  output logic [31:0] cmd_rdata_o,
  output logic cmd_rvalid_o,
  // event sources, one-cycle pulses from the host engine
  input wire logic [31:0] evt_set_i,
  // interrupt request to the host processor
  output logic host_irq_o
);
  // ****************************************************************
  // decode
  // ****************************************************************
  logic [31:0] mask_r;
  logic [31:0] mask_nxt;
  logic [31:0] evt_r;
  logic [31:0] evt_sync1_r;
  logic [31:0] evt_sync2_r;
  logic [31:0] evt_prev_r;
  logic [31:0] evt_pulse;
  logic wr_set;
  logic wr_clr;
  logic wr_evt;

  function automatic logic is_cmd(input logic v, input logic [7:0] c, input logic [7:0] k);
    is_cmd = v && (c == k);
  endfunction

  assign wr_set = is_cmd(cmd_valid_i, cmd_code_i, himc_pkg::CMD_SET_WR);
  assign wr_clr = is_cmd(cmd_valid_i, cmd_code_i, himc_pkg::CMD_CLR_WR);

  assign wr_evt = is_cmd(cmd_valid_i, cmd_code_i, himc_pkg::CMD_EVT_WR);

  // ****************************************************************
  // mask register: set and clear ports share one storage
  // ****************************************************************
  himc_reg_update u_upd (
    .cur_i(mask_r),
    .wdata_i(cmd_wdata_i),
    .set_i(wr_set),
    .clr_i(wr_clr),
    .nxt_o(mask_nxt)
  );

  // one storage only, so a clear read can never disagree with the set view
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mask_r <= himc_pkg::MASK_RESET;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // ****************************************************************
  // event flags
  // ****************************************************************
  // event pins come from outside the domain: two flops first
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      evt_sync1_r <= himc_pkg::EVT_RESET;
      evt_sync2_r <= himc_pkg::EVT_RESET;
      evt_prev_r <= himc_pkg::EVT_RESET;
    end else begin
      evt_sync1_r <= evt_set_i;
      evt_sync2_r <= evt_sync1_r;
      evt_prev_r <= evt_sync2_r;
    end
  end

  assign evt_pulse = evt_sync2_r & ~evt_prev_r & himc_pkg::EVT_VALID;

  // write-one-to-clear; a new event in the clear cycle wins
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      evt_r <= himc_pkg::EVT_RESET;
    end else begin
      evt_r <= (wr_evt ? (evt_r & ~cmd_wdata_i) : evt_r) | evt_pulse;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // unknown codes with bit 7 clear answer zero with rvalid so the host never hangs
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cmd_rdata_o <= himc_pkg::DATA_ZERO;
      cmd_rvalid_o <= 1'b0;
    end else begin
      cmd_rvalid_o <= cmd_valid_i && !cmd_code_i[7];
      if (cmd_valid_i && !cmd_code_i[7]) begin
        unique case (cmd_code_i)
          himc_pkg::CMD_SET_RD: cmd_rdata_o <= mask_r & himc_pkg::MASK_VALID;
          himc_pkg::CMD_CLR_RD: cmd_rdata_o <= mask_r & himc_pkg::MASK_VALID;
          himc_pkg::CMD_EVT_RD: cmd_rdata_o <= evt_r;
          default: cmd_rdata_o <= himc_pkg::DATA_ZERO;
        endcase
      end
    end
  end

  // ****************************************************************
  // interrupt output
  // ****************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      host_irq_o <= 1'b0;
    end else begin
      host_irq_o <= mask_r[himc_pkg::BIT_GATE] && |(evt_r & mask_r & himc_pkg::EVT_VALID);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  // mask storage, read view and request cause
  chk_clear_one_wins: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_clr |=> ((mask_r & $past(cmd_wdata_i) & himc_pkg::MASK_VALID) == 32'h0000_0000))
    else $error("mask bit survived a clear write");
  chk_clear_zero_holds: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_clr |=> ((mask_r & ~$past(cmd_wdata_i)) == ($past(mask_r) & ~$past(cmd_wdata_i))))
    else $error("zero in clear write changed mask");
  chk_clear_read_mask: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (cmd_valid_i && cmd_code_i == himc_pkg::CMD_CLR_RD && !wr_set) |=> (cmd_rdata_o == $past(mask_r)))
    else $error("clear read differs from mask");
  chk_gate_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_clr && cmd_wdata_i[himc_pkg::BIT_GATE]) |=> ##1 !host_irq_o)
    else $error("irq after master gate clear");
  chk_low_bits_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_clr && cmd_wdata_i[himc_pkg::BIT_ROOT] && cmd_wdata_i[himc_pkg::BIT_FATAL])
      |=> !mask_r[himc_pkg::BIT_ROOT] && !mask_r[himc_pkg::BIT_FATAL])
    else $error("event mask not cleared");
  chk_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (mask_r & ~himc_pkg::MASK_VALID) == 32'h0000_0000)
    else $error("reserved mask bit set");
  chk_set_one: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    wr_set |=> ((mask_r & $past(cmd_wdata_i) & himc_pkg::MASK_VALID)
      == ($past(cmd_wdata_i) & himc_pkg::MASK_VALID)))
    else $error("mask bit not set");
  chk_irq_cause: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    host_irq_o |-> $past(mask_r[himc_pkg::BIT_GATE]) && (($past(evt_r) & $past(mask_r)) != 32'h0000_0000))
    else $error("irq without cause");
  chk_set_read_mask: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (cmd_valid_i && cmd_code_i == himc_pkg::CMD_SET_RD) |=> cmd_rvalid_o && cmd_rdata_o == $past(mask_r))
    else $error("set read differs from mask");

  // ****************************************************************
  // checks: single-bit clears and code selection
  // ****************************************************************
  // one check per bit, for root, frame wrap, resume, frame start and overrun; fatal has none of its own, gate is checked through the request by chk_gate_clear
  chk_root_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_clr && cmd_wdata_i[himc_pkg::BIT_ROOT]) |=> !mask_r[himc_pkg::BIT_ROOT])
    else $error("root hub mask survived a clear write");
  chk_fwrap_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_clr && cmd_wdata_i[himc_pkg::BIT_FWRAP]) |=> !mask_r[himc_pkg::BIT_FWRAP])
    else $error("frame wrap mask survived a clear write");
  chk_resume_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_clr && cmd_wdata_i[himc_pkg::BIT_RESUME]) |=> !mask_r[himc_pkg::BIT_RESUME])
    else $error("resume mask survived a clear write");
  chk_fstart_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_clr && cmd_wdata_i[himc_pkg::BIT_FSTART]) |=> !mask_r[himc_pkg::BIT_FSTART])
    else $error("frame start mask survived a clear write");
  chk_overrun_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (wr_clr && cmd_wdata_i[himc_pkg::BIT_OVERRUN]) |=> !mask_r[himc_pkg::BIT_OVERRUN])
    else $error("overrun mask survived a clear write");
  // only the two mask write codes may touch the storage; event writes must not
  chk_other_code_holds: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !(wr_set || wr_clr) |=> $stable(mask_r))
    else $error("mask changed without a mask write");

  // ****************************************************************
  // checks: read answers and request raise
  // ****************************************************************
  // writes give no answer strobe, so the host cannot mistake one for a read
  chk_write_silent: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (cmd_valid_i && cmd_code_i[7]) |=> !cmd_rvalid_o)
    else $error("write answered with rvalid");
  chk_event_read: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (cmd_valid_i && cmd_code_i == himc_pkg::CMD_EVT_RD) |=> cmd_rvalid_o && cmd_rdata_o == $past(evt_r))
    else $error("event read differs from flags");
  chk_reserved_read: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (cmd_valid_i && cmd_code_i == himc_pkg::CMD_CLR_RD) |=> ((cmd_rdata_o & ~himc_pkg::MASK_VALID) == 32'h0000_0000))
    else $error("reserved bit read back as one");
  // an armed event with the gate open must raise the request next cycle
  chk_irq_raise: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (mask_r[himc_pkg::BIT_GATE] && ((evt_r & mask_r & himc_pkg::EVT_VALID) != 32'h0000_0000))
      |=> host_irq_o)
    else $error("armed event raised no irq");

  // ****************************************************************
  // cover points
  // ****************************************************************
  // request edges, the clear and event reads and an event held off by the gate
  cov_irq_raised: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) $rose(host_irq_o));
  cov_irq_dropped: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) wr_clr ##2 $fell(host_irq_o));
  cov_clear_read: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    cmd_valid_i && cmd_code_i == himc_pkg::CMD_CLR_RD);
  cov_event_read: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    cmd_valid_i && cmd_code_i == himc_pkg::CMD_EVT_RD);
  cov_gate_held_off: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !mask_r[himc_pkg::BIT_GATE] && ((evt_r & mask_r) != 32'h0000_0000));
endmodule

// >>> verification/himc_host_model.sv
`timescale 1ns/1ps
// host processor side of the command port
module himc_host_model (
  // clock
  input wire logic sys_clk_i,
  // command port toward the device
  output logic cmd_valid_o,
  output logic [7:0] cmd_code_o,
  output logic [31:0] cmd_wdata_o,
  // read answer
  input wire logic [31:0] cmd_rdata_i,
  input wire logic cmd_rvalid_i
);
  // idle bus at time zero
  initial begin
    cmd_valid_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_wdata_o = 32'h5555_5555;
  end
  // one-cycle write strobe; idle data inverted so stale words never match
  task automatic wr(input logic [7:0] code, input logic [31:0] data);
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b1;
    cmd_code_o = code;
    cmd_wdata_o = data;
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b0;
    cmd_wdata_o = ~data;
  endtask
  // read answer is registered on the taking edge and sampled half a cycle later
  task automatic rd(input logic [7:0] code, output logic [31:0] data, output logic rv);
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b1;
    cmd_code_o = code;
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b0;
    data = cmd_rdata_i;
    rv = cmd_rvalid_i;
  endtask
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_i, sys_rst_i, cmd_valid_i, cmd_rvalid_o, host_irq_o, rv;
  logic [7:0] cmd_code_i;
  logic [31:0] cmd_wdata_i, cmd_rdata_o, evt_set_i, rd_v, exp_m, bm;
  int fails = 0;
  int num_checks = 0;
  localparam int CLR_BITS [7] = '{31, 6, 5, 4, 3, 2, 0};
  // ****************************************************************
  // clock, design and host
  // ****************************************************************
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  himc_top i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i), .cmd_rdata_o(cmd_rdata_o),
    .cmd_rvalid_o(cmd_rvalid_o), .evt_set_i(evt_set_i), .host_irq_o(host_irq_o));
  himc_host_model i_host (.sys_clk_i(sys_clk_i), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
    .cmd_wdata_o(cmd_wdata_i), .cmd_rdata_i(cmd_rdata_o), .cmd_rvalid_i(cmd_rvalid_o));
  // ****************************************************************
  // checking helpers
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // read, then demand the answer strobe and the word
  task automatic rd_chk(input logic [7:0] code, input logic [31:0] exp);
    i_host.rd(code, rd_v, rv);
    check("rvalid", {31'h0000_0000, rv}, 32'h0000_0001);
    check("rdata", rd_v, exp);
  endtask
  task automatic irq_chk(input logic exp);
    @(negedge sys_clk_i);
    check("irq", {31'h0000_0000, host_irq_o}, {31'h0000_0000, exp});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles of the tests
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    fails++;
    tally_and_finish();
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    sys_rst_i = 1'b1;
    evt_set_i = 32'h0000_0000;
    repeat (16) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    rd_chk(himc_pkg::CMD_CLR_RD, himc_pkg::MASK_RESET);
    rd_chk(himc_pkg::CMD_SET_RD, himc_pkg::MASK_RESET);
    $display("test reset values done");
    i_host.wr(himc_pkg::CMD_SET_WR, 32'hFFFF_FFFF);
    rd_chk(himc_pkg::CMD_SET_RD, himc_pkg::MASK_VALID);
    i_host.wr(himc_pkg::CMD_CLR_WR, 32'h0000_0000);
    rd_chk(himc_pkg::CMD_CLR_RD, himc_pkg::MASK_VALID);
    i_host.wr(himc_pkg::CMD_CLR_WR, 32'h7FFF_FF82);
    rd_chk(himc_pkg::CMD_CLR_RD, himc_pkg::MASK_VALID);
    exp_m = himc_pkg::MASK_VALID;
    // one bit at a time, each clear must leave the others alone
    foreach (CLR_BITS[i]) begin
      i_host.wr(himc_pkg::CMD_CLR_WR, 32'h0000_0001 << CLR_BITS[i]);
      exp_m[CLR_BITS[i]] = 1'b0;
      rd_chk(himc_pkg::CMD_CLR_RD, exp_m);
    end
    // two positions in one write, both must drop
    i_host.wr(himc_pkg::CMD_SET_WR, 32'hFFFF_FFFF);
    i_host.wr(himc_pkg::CMD_CLR_WR, 32'h0000_0050);
    rd_chk(himc_pkg::CMD_CLR_RD, himc_pkg::MASK_VALID & ~32'h0000_0050);
    // a code outside the map answers zero and never reaches the mask
    rd_chk(8'h7F, himc_pkg::DATA_ZERO);
    $display("test mask clear bits done");
    // each event alone: mask bit, gate and event all needed
    for (int i = 1; i < 7; i++) begin
      bm = 32'h0000_0001 << CLR_BITS[i];
      i_host.wr(himc_pkg::CMD_SET_WR, 32'hFFFF_FFFF);
      i_host.wr(himc_pkg::CMD_CLR_WR, bm);
      evt_set_i = bm;
      repeat (6) @(negedge sys_clk_i);
      evt_set_i = 32'h0000_0000;
      irq_chk(1'b0);
      rd_chk(himc_pkg::CMD_EVT_RD, bm);
      i_host.wr(himc_pkg::CMD_SET_WR, bm);
      irq_chk(1'b1);
      i_host.wr(himc_pkg::CMD_CLR_WR, bm);
      irq_chk(1'b0);
      i_host.wr(himc_pkg::CMD_SET_WR, bm);
      i_host.wr(himc_pkg::CMD_CLR_WR, 32'h8000_0000);
      irq_chk(1'b0);
      i_host.wr(himc_pkg::CMD_EVT_WR, bm);
      rd_chk(himc_pkg::CMD_EVT_RD, himc_pkg::EVT_RESET);
      i_host.wr(himc_pkg::CMD_SET_WR, 32'h8000_0000);
      irq_chk(1'b0);
    end
    $display("test interrupt gating done");
    tally_and_finish();
  end
endmodule
